//--- design/uims_pkg.sv
package uims_pkg;

  localparam int UIMS_ADDR_W = 12;
  localparam int UIMS_DATA_W = 32;
  localparam int UIMS_NUM_SRC = 11;

  // Register byte offsets
  localparam logic [11:0] UIMS_OFS_LEVEL_SEL = 12'h0034;
  localparam logic [11:0] UIMS_OFS_MASK = 12'h0038;
  localparam logic [11:0] UIMS_OFS_RAW = 12'h003c;
  localparam logic [11:0] UIMS_OFS_GATED = 12'h0040;
  localparam logic [11:0] UIMS_OFS_CLEAR = 12'h0044;

  // Source bit positions, shared by all four registers
  localparam int UIMS_BIT_OVERRUN = 10;
  localparam int UIMS_BIT_BREAK = 9;
  localparam int UIMS_BIT_PARITY = 8;
  localparam int UIMS_BIT_FRAMING = 7;
  localparam int UIMS_BIT_TIMEOUT = 6;
  localparam int UIMS_BIT_TRANSMIT = 5;
  localparam int UIMS_BIT_RECEIVE = 4;
  localparam int UIMS_BIT_SET_READY = 3;
  localparam int UIMS_BIT_CARRIER = 2;
  localparam int UIMS_BIT_CLEAR_TO_SEND = 1;
  localparam int UIMS_BIT_RING = 0;
  localparam int UIMS_MODEM_HI = 3;

  // Level select fields
  localparam int UIMS_TX_SEL_LSB = 0;
  localparam int UIMS_RX_SEL_LSB = 3;
  localparam int UIMS_SEL_W = 3;
  localparam logic [2:0] UIMS_SEL_RST = 3'h2;
  localparam logic [2:0] UIMS_SEL_MAX = 3'h4;

  localparam logic [10:0] UIMS_MASK_RST = 11'h000;
  localparam logic [10:0] UIMS_LATCH_RST = 11'h000;
  localparam logic [31:0] UIMS_ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } uims_req_t;

  typedef struct packed {
    logic overrun;
    logic brk;
    logic parity;
    logic framing;
    logic timeout;
  } uims_err_evt_t;

endpackage : uims_pkg

//--- design/uims_irq_ctrl.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// RULE_01 - Mask bits 10..7 enable overrun, break, parity, framing errors.
// RULE_02 - Mask bit 6 timeout, bit 5 transmit, bit 4 receive enable.
// RULE_03 - Mask bits 3..0 enable set-ready, carrier, clear-to-send, ring changes.
// RULE_04 - Mask bits read back; write 1 enables, write 0 disables.
// RULE_05 - Mask resets to zero so nothing is gated through.
// RULE_06 - Raw state is read-only, bits 10..0 same layout as mask.
// RULE_07 - Raw error, timeout, transmit, receive bits reset to zero.
// RULE_08 - Modem raw and gated bits follow modem lines after reset; here they reset to zero and the first sample only seeds.
// RULE_09 - Gated bit equals raw bit AND its mask enable.
// RULE_10 - Gated state read-only; non-modem bits zero after reset.
// RULE_11 - Clear bits 10..7 clear error interrupts.
// RULE_12 - Clear bits 6..4 clear timeout, transmit, receive interrupts.
// RULE_13 - Clear bits 3..0 clear the four modem interrupts.
// RULE_14 - Decode mask 0x038, raw 0x03c, gated 0x040, clear 0x044.
// RULE_15 - Clear register only changes pending state; reads as zero.
// RULE_16 - FIFO fraction selects raise rx/tx; each 3-bit select resets to half.
// RULE_17 - Writing zero to a clear bit leaves that interrupt unchanged.
// RULE_18 - Bits 31..11 of the four registers read zero, ignore writes.
module uims_irq_ctrl
  import uims_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int LVL_W = 6
)(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [UIMS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [UIMS_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [UIMS_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_overrun_evt,
  input wire logic i_break_evt,
  input wire logic i_parity_evt,
  input wire logic i_framing_evt,
  input wire logic i_timeout_evt,
  input wire logic [LVL_W-1:0] i_rx_fill,
  input wire logic [LVL_W-1:0] i_tx_fill,
  input wire logic i_set_ready_line_n,
  input wire logic i_carrier_line_n,
  input wire logic i_clear_to_send_line_n,
  input wire logic i_ring_line_n,
  output logic [UIMS_NUM_SRC-1:0] o_gated_irq,
  output logic o_irq
);

  // Thresholds are whole eighths of the depth, and the fill count must reach it
  if (FIFO_DEPTH < 8 || FIFO_DEPTH % 8 != 0)
  begin : g_bad_depth
    $error("uims_irq_ctrl: FIFO_DEPTH must be a positive multiple of 8");
  end
  if ((1 << LVL_W) <= FIFO_DEPTH)
  begin : g_bad_lvl_w
    $error("uims_irq_ctrl: LVL_W too narrow for a full FIFO count");
  end
  if (UIMS_NUM_SRC > 16)
  begin : g_bad_src
    $error("uims_irq_ctrl: sources must fit byte lanes 0 and 1");
  end
  if (UIMS_SEL_W != 3)
  begin : g_bad_sel
    $error("uims_irq_ctrl: level selects are decoded as 3-bit codes");
  end

  // Fill threshold for a select code; reserved codes act as seven eighths
  function automatic logic [LVL_W:0] level_of(input logic [2:0] sel);
    logic [LVL_W+3:0] num;
    num = '0;
    case (sel)
      3'h0: num = (LVL_W+4)'(FIFO_DEPTH * 1);
      3'h1: num = (LVL_W+4)'(FIFO_DEPTH * 2);
      3'h2: num = (LVL_W+4)'(FIFO_DEPTH * 4);
      3'h3: num = (LVL_W+4)'(FIFO_DEPTH * 6);
      default: num = (LVL_W+4)'(FIFO_DEPTH * 7);
    endcase
    return num[LVL_W+3:3];
  endfunction : level_of

  function automatic logic [UIMS_DATA_W-1:0] pad_word(input logic [UIMS_NUM_SRC-1:0] v);
    return {{(UIMS_DATA_W-UIMS_NUM_SRC){1'b0}}, v};
  endfunction : pad_word

  // Bits 10..0 sit in byte lanes 0 and 1; a lane left out takes the keep value
  function automatic logic [UIMS_NUM_SRC-1:0] lane_merge(
    input logic [UIMS_NUM_SRC-1:0] keep,
    input logic [UIMS_DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [UIMS_NUM_SRC-1:0] v;
    v = keep;
    if (be[0])
    begin
      v[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      v[UIMS_NUM_SRC-1:8] = wd[UIMS_NUM_SRC-1:8];
    end
    return v;
  endfunction : lane_merge

  function automatic logic at_ofs(input logic [UIMS_ADDR_W-1:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : at_ofs

  typedef enum logic [1:0] {UIMS_IDLE, UIMS_ANSWER} uims_bus_st_t;

  uims_req_t req;
  uims_bus_st_t st_ff, nxt_st;
  logic [UIMS_NUM_SRC-1:0] mask_ff, nxt_mask;
  logic [UIMS_NUM_SRC-1:0] latch_ff, nxt_latch;
  logic [UIMS_MODEM_HI:0] line_ff, nxt_line;
  logic line_ok_ff, nxt_line_ok;
  logic [UIMS_SEL_W-1:0] rx_sel_ff, nxt_rx_sel;
  logic [UIMS_SEL_W-1:0] tx_sel_ff, nxt_tx_sel;
  logic rx_above_ff, nxt_rx_above;
  logic tx_below_ff, nxt_tx_below;
  logic [UIMS_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;
  logic [UIMS_NUM_SRC-1:0] gated_ff, nxt_gated;
  logic irq_ff, nxt_irq;
  logic [UIMS_NUM_SRC-1:0] set_vec, clr_vec, raw_vec;
  logic [UIMS_MODEM_HI:0] line_now;
  logic rx_above, tx_below, wr_take, rd_take;
  uims_err_evt_t err_evt;
  logic [UIMS_MODEM_HI:0] modem_chg;

  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                 writedata: i_avs_writedata, byteenable: i_avs_byteenable};
  assign line_now = {i_set_ready_line_n, i_carrier_line_n,
                     i_clear_to_send_line_n, i_ring_line_n};
  assign err_evt = '{overrun: i_overrun_evt, brk: i_break_evt, parity: i_parity_evt,
                     framing: i_framing_evt, timeout: i_timeout_evt};

  // Modem change only once a reference sample exists
  for (genvar m = 0; m <= UIMS_MODEM_HI; m++)
  begin : g_modem
    assign modem_chg[m] = line_ok_ff && (line_now[m] != line_ff[m]); // [RULE_08]
  end

  assign rx_above = {1'b0, i_rx_fill} >= level_of(rx_sel_ff); // [RULE_16]
  assign tx_below = {1'b0, i_tx_fill} <= level_of(tx_sel_ff); // [RULE_16]
  // Reads are sampled when taken; writes commit at the answer edge, the only
  // edge at which the master is bound to still hold address and data
  assign wr_take = (st_ff == UIMS_ANSWER) && req.write;
  assign rd_take = (st_ff == UIMS_IDLE) && req.read && !req.write;

  // Event sources
  always_comb
  begin
    set_vec = '0;
    set_vec[UIMS_BIT_OVERRUN] = err_evt.overrun;
    set_vec[UIMS_BIT_BREAK] = err_evt.brk;
    set_vec[UIMS_BIT_PARITY] = err_evt.parity;
    set_vec[UIMS_BIT_FRAMING] = err_evt.framing;
    set_vec[UIMS_BIT_TIMEOUT] = err_evt.timeout;
    // Threshold crossing edges, not levels, so a clear sticks; the first edge
    // after reset only seeds the detectors, so an empty FIFO raises nothing yet
    set_vec[UIMS_BIT_RECEIVE] = line_ok_ff && rx_above && !rx_above_ff; // [RULE_16] [RULE_07]
    set_vec[UIMS_BIT_TRANSMIT] = line_ok_ff && tx_below && !tx_below_ff; // [RULE_16] [RULE_07]
    set_vec[UIMS_MODEM_HI:0] = modem_chg; // [RULE_08]
  end

  // Clear strobes: byte lanes 0 and 1 hold bits 10..0
  always_comb
  begin
    clr_vec = '0;
    if (wr_take && at_ofs(req.address, UIMS_OFS_CLEAR))
    begin
      clr_vec = lane_merge('0, req.writedata, req.byteenable); // [RULE_11] [RULE_12] [RULE_13]
    end
  end

  // One pending flag per source; set beats clear in the same cycle
  for (genvar g = 0; g < UIMS_NUM_SRC; g++)
  begin : g_pend
    assign nxt_latch[g] = set_vec[g] | (latch_ff[g] & ~clr_vec[g]); // [RULE_17]
  end

  // Detector reference samples
  always_comb
  begin
    nxt_line = line_now;
    nxt_line_ok = 1'b1;
    nxt_rx_above = rx_above;
    nxt_tx_below = tx_below;
  end

  assign raw_vec = latch_ff; // [RULE_06] [RULE_07]

  // Configuration registers
  always_comb
  begin
    nxt_mask = mask_ff;
    nxt_rx_sel = rx_sel_ff;
    nxt_tx_sel = tx_sel_ff;
    // A lane left out keeps its bits; bits 31..11 have no storage at all
    if (wr_take && at_ofs(req.address, UIMS_OFS_MASK)) // [RULE_01] [RULE_02] [RULE_03]
    begin
      nxt_mask = lane_merge(mask_ff, req.writedata, req.byteenable); // [RULE_04] [RULE_18]
    end
    if (wr_take && at_ofs(req.address, UIMS_OFS_LEVEL_SEL) && req.byteenable[0])
    begin
      nxt_tx_sel = req.writedata[UIMS_TX_SEL_LSB +: UIMS_SEL_W]; // [RULE_16]
      nxt_rx_sel = req.writedata[UIMS_RX_SEL_LSB +: UIMS_SEL_W]; // [RULE_16]
    end
  end

  // Bus handshake and read mux
  // Waitrequest idles high, so no request completes in the cycle it appears
  always_comb
  begin
    nxt_st = st_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    case (st_ff)
      UIMS_IDLE:
      begin
        if (req.read || req.write)
        begin
          nxt_st = UIMS_ANSWER;
          nxt_wait = 1'b0;
          nxt_rdata = UIMS_ZERO_WORD;
          if (rd_take)
          begin
            case (req.address) // [RULE_14]
              UIMS_OFS_MASK: nxt_rdata = pad_word(mask_ff); // [RULE_04] [RULE_18]
              UIMS_OFS_RAW: nxt_rdata = pad_word(raw_vec); // [RULE_06] [RULE_18]
              UIMS_OFS_GATED: nxt_rdata = pad_word(raw_vec & mask_ff); // [RULE_09] [RULE_10]
              UIMS_OFS_LEVEL_SEL: nxt_rdata = {26'h000_0000, rx_sel_ff, tx_sel_ff};
              // Clear register and unmapped offsets read zero
              default: nxt_rdata = UIMS_ZERO_WORD; // [RULE_15]
            endcase
          end
        end
      end
      UIMS_ANSWER:
      begin
        nxt_st = UIMS_IDLE;
        nxt_wait = 1'b1;
      end
      default:
      begin
        nxt_st = UIMS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  // Interrupt outputs
  always_comb
  begin
    nxt_gated = nxt_latch & nxt_mask; // [RULE_09] [RULE_05]
    nxt_irq = |(nxt_latch & nxt_mask);
  end

  // Bus handshake state
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff <= UIMS_IDLE;
      rdata_ff <= UIMS_ZERO_WORD;
      wait_ff <= 1'b1;
    end
    else if (i_clk_en)
    begin
      st_ff <= nxt_st;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  // Configuration registers
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mask_ff <= UIMS_MASK_RST; // [RULE_05]
      rx_sel_ff <= UIMS_SEL_RST; // [RULE_16]
      tx_sel_ff <= UIMS_SEL_RST; // [RULE_16]
    end
    else if (i_clk_en)
    begin
      mask_ff <= nxt_mask;
      rx_sel_ff <= nxt_rx_sel;
      tx_sel_ff <= nxt_tx_sel;
    end
  end

  // Change detector references
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      line_ff <= '0;
      line_ok_ff <= 1'b0;
      rx_above_ff <= 1'b0;
      tx_below_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      line_ff <= nxt_line;
      line_ok_ff <= nxt_line_ok;
      rx_above_ff <= nxt_rx_above;
      tx_below_ff <= nxt_tx_below;
    end
  end

  // Pending flags
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      latch_ff <= UIMS_LATCH_RST; // [RULE_07] [RULE_10]
    end
    else if (i_clk_en)
    begin
      latch_ff <= nxt_latch;
    end
  end

  // Registered interrupt outputs
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      gated_ff <= '0;
      irq_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      gated_ff <= nxt_gated;
      irq_ff <= nxt_irq;
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign o_gated_irq = gated_ff;
  assign o_irq = irq_ff;

endmodule : uims_irq_ctrl

//--- testbench/uims_irq_ctrl_assertions.sv
`timescale 1ns/1ps
module uims_irq_ctrl_assertions
  import uims_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [UIMS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [UIMS_DATA_W-1:0] i_avs_writedata,
  input wire logic [UIMS_DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_overrun_evt,
  input wire logic [UIMS_NUM_SRC-1:0] o_gated_irq,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic clr_tk;
  assign clr_tk = i_avs_write && !o_avs_waitrequest && i_clk_en && i_avs_address == UIMS_OFS_CLEAR;
  AST_IRQ_OR: assert property (o_irq == |o_gated_irq)
    else $error("irq differs from any gated bit");
  AST_RST_VAL: assert property ($rose(i_rst_b) |-> o_gated_irq == 11'h000 && !o_irq)
    else $error("gated state not zero after reset");
  AST_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");
  AST_HI_ZERO: assert property ($fell(o_avs_waitrequest) && $past(i_avs_read)
    |-> o_avs_readdata[31:11] == 21'h00_0000)
    else $error("upper read bits not zero");
  AST_CLR_READ: assert property ($fell(o_avs_waitrequest) && $past(i_avs_read)
    && $past(i_avs_address) == UIMS_OFS_CLEAR |-> o_avs_readdata == 32'h0000_0000)
    else $error("clear register read not zero");
  AST_GATED_RD: assert property ($fell(o_avs_waitrequest) && $past(i_avs_read)
    && $past(i_avs_address) == UIMS_OFS_GATED |-> o_avs_readdata[10:0] == $past(o_gated_irq))
    else $error("gated read differs from gated output");
  AST_OVR_CAUSE: assert property ($rose(o_gated_irq[10]) |-> $past(i_overrun_evt) || $past(i_avs_write))
    else $error("overrun gated bit rose without cause");
  AST_CLR_ONE: assert property (clr_tk && i_avs_writedata[10] && !i_overrun_evt |=> !o_gated_irq[10])
    else $error("overrun not cleared");
  AST_CLR_ZERO: assert property (clr_tk && !i_avs_writedata[10] && o_gated_irq[10] |=> o_gated_irq[10])
    else $error("overrun cleared by zero");
endmodule : uims_irq_ctrl_assertions

//--- testbench/uims_irq_ctrl_tb.sv
`timescale 1ns/1ps
module uims_irq_ctrl_tb;
  import uims_pkg::*;
  logic i_core_clk = 1'h0;
  logic i_rst_b = 1'h0;
  logic [11:0] i_avs_address = 12'h000;
  logic i_avs_read = 1'h0;
  logic i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [4:0] evt = 5'h00;
  logic [5:0] rxf = 6'h00;
  // Empty transmit FIFO: must not raise transmit right after reset
  logic [5:0] txf = 6'h00;
  logic clk_en = 1'h1;
  logic [3:0] be = 4'hf;
  logic [3:0] mdm = 4'hf;
  logic [10:0] o_gated_irq;
  logic o_irq;
  logic [31:0] q;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #20 i_core_clk = ~i_core_clk;
  uims_irq_ctrl uims_irq_ctrl_inst (.i_core_clk, .i_rst_b, .i_clk_en(clk_en), .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable(be), .o_avs_readdata,
    .o_avs_waitrequest, .i_overrun_evt(evt[4]), .i_break_evt(evt[3]), .i_parity_evt(evt[2]),
    .i_framing_evt(evt[1]), .i_timeout_evt(evt[0]), .i_rx_fill(rxf), .i_tx_fill(txf),
    .i_set_ready_line_n(mdm[3]), .i_carrier_line_n(mdm[2]), .i_clear_to_send_line_n(mdm[1]),
    .i_ring_line_n(mdm[0]), .o_gated_irq, .o_irq);
  task conclude;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'h0)
      @(posedge i_core_clk);
    q = o_avs_readdata;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask : acc
  task rchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rchk
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'h1;
    rchk(UIMS_OFS_MASK, 32'h0000_0000);
    rchk(UIMS_OFS_RAW, 32'h0000_0000);
    rchk(UIMS_OFS_GATED, 32'h0000_0000);
    rchk(UIMS_OFS_CLEAR, 32'h0000_0000);
    rchk(UIMS_OFS_LEVEL_SEL, 32'h0000_0012);
    $display("test reset done");
    for (int i = 0; i < 11; i++)
    begin
      acc(1'h1, UIMS_OFS_MASK, 32'h0000_0001 << i);
      rchk(UIMS_OFS_MASK, 32'h0000_0001 << i);
    end
    acc(1'h1, UIMS_OFS_MASK, 32'hffff_ffff);
    rchk(UIMS_OFS_MASK, 32'h0000_07ff);
    acc(1'h1, UIMS_OFS_MASK, 32'h0000_0000);
    rchk(UIMS_OFS_MASK, 32'h0000_0000);
    $display("test mask done");
    @(posedge i_core_clk);
    evt <= 5'h1f;
    @(posedge i_core_clk);
    evt <= 5'h00;
    rchk(UIMS_OFS_RAW, 32'h0000_07c0);
    rchk(UIMS_OFS_GATED, 32'h0000_0000);
    chk({31'h0000_0000, o_irq}, 32'h0000_0000);
    acc(1'h1, UIMS_OFS_MASK, 32'h0000_0680);
    rchk(UIMS_OFS_GATED, 32'h0000_0680);
    chk({31'h0000_0000, o_irq}, 32'h0000_0001);
    acc(1'h1, UIMS_OFS_RAW, 32'h0000_07ff);
    rchk(UIMS_OFS_RAW, 32'h0000_07c0);
    acc(1'h1, 12'h100, 32'hffff_ffff);
    rchk(12'h100, 32'h0000_0000);
    $display("test events done");
    acc(1'h1, UIMS_OFS_CLEAR, 32'h0000_0100);
    rchk(UIMS_OFS_RAW, 32'h0000_06c0);
    acc(1'h1, UIMS_OFS_CLEAR, 32'h0000_0040);
    rchk(UIMS_OFS_RAW, 32'h0000_0680);
    acc(1'h1, UIMS_OFS_CLEAR, 32'hffff_f800);
    rchk(UIMS_OFS_RAW, 32'h0000_0680);
    acc(1'h1, UIMS_OFS_CLEAR, 32'h0000_0680);
    rchk(UIMS_OFS_RAW, 32'h0000_0000);
    chk({31'h0000_0000, o_irq}, 32'h0000_0000);
    $display("test clear done");
    @(posedge i_core_clk);
    txf <= 6'h14;
    @(posedge i_core_clk);
    rxf <= 6'h10;
    txf <= 6'h0a;
    rchk(UIMS_OFS_RAW, 32'h0000_0030);
    acc(1'h1, UIMS_OFS_CLEAR, 32'h0000_0030);
    rchk(UIMS_OFS_RAW, 32'h0000_0000);
    $display("test fifo done");
    @(posedge i_core_clk);
    mdm <= 4'ha;
    acc(1'h1, UIMS_OFS_MASK, 32'h0000_0001);
    rchk(UIMS_OFS_RAW, 32'h0000_0005);
    rchk(UIMS_OFS_GATED, 32'h0000_0001);
    chk({21'h00_0000, o_gated_irq}, 32'h0000_0001);
    acc(1'h1, UIMS_OFS_CLEAR, 32'h0000_000f);
    rchk(UIMS_OFS_RAW, 32'h0000_0000);
    $display("test modem done");
    be <= 4'h1;
    acc(1'h1, UIMS_OFS_MASK, 32'h0000_07fe);
    rchk(UIMS_OFS_MASK, 32'h0000_00fe);
    be <= 4'hf;
    @(posedge i_core_clk);
    clk_en <= 1'h0;
    evt <= 5'h10;
    @(posedge i_core_clk);
    evt <= 5'h00;
    @(posedge i_core_clk);
    clk_en <= 1'h1;
    rchk(UIMS_OFS_RAW, 32'h0000_0000);
    $display("test lanes and enable done");
    conclude();
  end
endmodule : uims_irq_ctrl_tb
bind uims_irq_ctrl uims_irq_ctrl_assertions uims_irq_ctrl_assertions_inst (.i_core_clk,
  .i_rst_b, .i_clk_en, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_readdata, .o_avs_waitrequest, .i_overrun_evt, .o_gated_irq, .o_irq);
